// ==== ces_pkg.sv ====
// Package for the CAN error-count and FIFO status block: offsets, limits, types.
// Assumes a single 200 MHz APB clock domain and an active-low async reset.
//
// Summary of operation
// R1 - Transmit bus-off flag (bit 21) set while transmit error count is 256 or more.
// R2 - Transmit bus-passive flag (bit 20) set while transmit error count is 128 or more.
// R3 - Receive bus-passive flag (bit 19) set while receive error count is 128 or more.
// R4 - Transmit warning flag (bit 18) set only while count is 96 to 127.
// R5 - Receive warning flag (bit 17) set only while count is 96 to 127.
// R6 - Combined warning flag (bit 16) is transmit warning or receive warning.
// R7 - Transmit count in bits 15-8, receive count in bits 7-0, read-only, reset zero.
// R8 - Bits 31-22 of the error-count register always read zero.
// R9 - Per-FIFO pending bit is one while any enabled interrupt of that FIFO pends.
// R10 - Per-FIFO overflow bit is one once that FIFO overflowed on reception.
// R11 - Interrupt code reports index of pending FIFO, codes 0 to 31.
// R12 - Receive-buffer overrun flag rises whenever any receive FIFO overflows.
// R13 - Error counts follow CAN fault-confinement increments and decrements.
package ces_pkg;

   // ----------------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------------
   localparam logic [7:0] CES_OFF_ERR_COUNT  = 8'h00;
   localparam logic [7:0] CES_OFF_FIFO_PEND  = 8'h04;
   localparam logic [7:0] CES_OFF_FIFO_OVF   = 8'h08;
   localparam logic [7:0] CES_OFF_IRQ_STATUS = 8'h0c;
   localparam logic [7:0] CES_OFF_IRQ_MASK   = 8'h10;
   localparam logic [7:0] CES_OFF_FIFO_EN    = 8'h14;

   // ----------------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------------
   localparam int CES_BIT_TX_BUS_OFF  = 21;
   localparam int CES_BIT_TX_PASSIVE  = 20;
   localparam int CES_BIT_RX_PASSIVE  = 19;
   localparam int CES_BIT_TX_WARNING  = 18;
   localparam int CES_BIT_RX_WARNING  = 17;
   localparam int CES_BIT_ANY_WARNING = 16;
   localparam int CES_IRQ_OVERRUN     = 0;
   localparam int CES_IRQ_STATE_CHG   = 1;
   localparam int CES_IRQ_BUS_OFF     = 2;
   localparam int CES_IRQ_BITS        = 3;
   localparam logic [31:0] CES_RESET_WORD = 32'h0000_0000;

   // ----------------------------------------------------------------------
   // Fault-confinement limits
   // ----------------------------------------------------------------------
   localparam logic [8:0] CES_WARN_LIMIT    = 9'h060;  // 96
   localparam logic [8:0] CES_PASSIVE_LIMIT = 9'h080;  // 128
   localparam logic [8:0] CES_BUS_OFF_LIMIT = 9'h100;  // 256
   localparam logic [8:0] CES_STEP_ERROR    = 9'h008;
   localparam logic [8:0] CES_STEP_ONE      = 9'h001;
   localparam logic [8:0] CES_RX_REENTRY    = 9'h078;  // 120, inside 119..127

   // ----------------------------------------------------------------------
   // Interrupt codes
   // ----------------------------------------------------------------------
   localparam logic [6:0] CES_CODE_NONE    = 7'h40;
   localparam logic [6:0] CES_CODE_OVERRUN = 7'h43;

   // ----------------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic tx_bus_off_flag;
      logic tx_bus_passive_flag;
      logic rx_bus_passive_flag;
      logic tx_warning_flag;
      logic rx_warning_flag;
      logic any_warning_flag;
   } ces_err_flags_s;

   typedef struct packed {
      logic tx_error;      // Transmitter detected an error, +8
      logic tx_success;    // Frame sent, -1
      logic rx_error;      // Receiver error, +1
      logic rx_severe;     // Receiver dominant-bit error, +8
      logic rx_success;    // Frame received, -1 or reentry
      logic bus_recovered; // 128 x 11 recessive bits seen, clears both
   } ces_err_events_s;

   typedef enum logic [1:0] {
      CES_ST_IDLE   = 2'b00,
      CES_ST_ACCESS = 2'b01
   } ces_apb_state_e;

endpackage

// ==== ces_err_counter.sv ====
// Saturating CAN error counter with fault-confinement steps.
// Assumes at most one event class wins per cycle, in the priority below.
`timescale 1ns/1ps
module ces_err_counter #(
   parameter int         WIDTH   = 9,
   parameter logic [8:0] MAXVAL  = 9'h100,
   parameter bit         REENTRY = 1'b0
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             clear,
   input  wire logic             inc_eight,
   input  wire logic             inc_one,
   input  wire logic             dec_one,
   output logic      [WIDTH-1:0] count_reg
);
   import ces_pkg::*;

   logic [WIDTH-1:0] count_next;
   logic [8:0]       wide;
   logic [9:0]       sum;

   // ----------------------------------------------------------------------
   // Next count
   // ----------------------------------------------------------------------
   // Saturate at MAXVAL; a bus-off counter freezes until recovery clears it
   always_comb begin
      wide = 9'(count_reg);
      sum  = {1'b0, wide};
      if (clear) begin
         sum = 10'h000;                                          // [R13]
      end else if (!REENTRY && wide >= MAXVAL) begin             // [R13]
         sum = {1'b0, MAXVAL};
      end else if (inc_eight) begin
         sum = {1'b0, wide} + {1'b0, CES_STEP_ERROR};            // [R13]
      end else if (inc_one) begin
         sum = {1'b0, wide} + {1'b0, CES_STEP_ONE};              // [R13]
      end else if (dec_one && REENTRY && wide > CES_PASSIVE_LIMIT - CES_STEP_ONE) begin
         sum = {1'b0, CES_RX_REENTRY};                           // [R13]
      end else if (dec_one && wide != 9'h000) begin
         sum = {1'b0, wide} - {1'b0, CES_STEP_ONE};              // [R13]
      end
      if (sum > {1'b0, MAXVAL}) begin
         sum = {1'b0, MAXVAL};
      end
      count_next = WIDTH'(sum);
   end

   // Counter register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_reg <= '0;
      end else begin
         count_reg <= count_next;
      end
   end

endmodule // ces_err_counter

// ==== ces_status.sv ====
// CAN error-count, FIFO pending and FIFO overflow status, with APB slave.
// Assumes error events and FIFO indications arrive synchronous to pclk.
`timescale 1ns/1ps
module ces_status #(
   parameter int NUM_FIFOS = 32
) (
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [7:0]               paddr,
   input  wire logic [31:0]              pwdata,
   input  wire logic [3:0]               pstrb,
   output logic      [31:0]              prdata,
   output logic                          pready,
   output logic                          pslverr,
   input  wire ces_pkg::ces_err_events_s err_events,
   input  wire logic [NUM_FIFOS-1:0]     fifo_irq_src,
   input  wire logic [NUM_FIFOS-1:0]     fifo_ovf_event,
   input  wire logic [NUM_FIFOS-1:0]     fifo_ovf_clear,
   output ces_pkg::ces_err_flags_s       err_flags,
   output logic      [6:0]               interrupt_code,
   output logic                          rx_buffer_overrun_flag,
   output logic                          irq
);
   import ces_pkg::*;

   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   logic [8:0]           tx_error_count;
   logic [7:0]           rx_error_count;
   ces_err_flags_s       flags_now;
   ces_err_flags_s       err_flags_reg;
   logic [NUM_FIFOS-1:0] fifo_event_pending_reg;
   logic [NUM_FIFOS-1:0] fifo_overflowed_reg;
   logic [NUM_FIFOS-1:0] fifo_enable_reg;
   logic [CES_IRQ_BITS-1:0] irq_status_reg;
   logic [CES_IRQ_BITS-1:0] irq_mask_reg;
   logic [CES_IRQ_BITS-1:0] irq_events;
   logic [CES_IRQ_BITS-1:0] irq_clear;
   logic [6:0]           interrupt_code_reg;
   logic [6:0]           interrupt_code_next;
   logic                 irq_reg;
   logic [31:0]          prdata_reg;
   logic [31:0]          read_word;
   logic                 pready_reg;
   logic                 pslverr_reg;
   logic                 addr_hit;
   logic                 setup;
   logic                 wr_commit;
   ces_apb_state_e       apb_state_reg;
   ces_apb_state_e       apb_state_next;

   // ----------------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------------
   // Lowest set bit wins so FIFO 0 has the highest priority
   function automatic logic [6:0] lowest_index(input logic [NUM_FIFOS-1:0] v);
      logic [6:0] idx;
      idx = CES_CODE_NONE;
      for (int i = NUM_FIFOS - 1; i >= 0; i--) begin
         if (v[i]) begin
            idx = 7'(i);
         end
      end
      return idx;
   endfunction

   // True when a count lies in the warning band, 96..127
   function automatic logic in_warning(input logic [8:0] cnt);
      return (cnt >= CES_WARN_LIMIT) && (cnt < CES_PASSIVE_LIMIT);
   endfunction

   // ----------------------------------------------------------------------
   // Error counters
   // ----------------------------------------------------------------------
   // Transmit counter goes to 256 so bus-off is visible; receive saturates at 255
   ces_err_counter #(
      .WIDTH   (9),
      .MAXVAL  (CES_BUS_OFF_LIMIT),
      .REENTRY (1'b0)
   ) u_tx_count (
      .pclk      (pclk),
      .presetn   (presetn),
      .clear     (err_events.bus_recovered),
      .inc_eight (err_events.tx_error),
      .inc_one   (1'b0),
      .dec_one   (err_events.tx_success),
      .count_reg (tx_error_count)
   );

   ces_err_counter #(
      .WIDTH   (8),
      .MAXVAL  (9'h0ff),
      .REENTRY (1'b1)
   ) u_rx_count (
      .pclk      (pclk),
      .presetn   (presetn),
      .clear     (err_events.bus_recovered),
      .inc_eight (err_events.rx_severe),
      .inc_one   (err_events.rx_error),
      .dec_one   (err_events.rx_success),
      .count_reg (rx_error_count)
   );

   // ----------------------------------------------------------------------
   // Error-state flags
   // ----------------------------------------------------------------------
   // Derived straight from the counts, so a read never shows a stale state
   always_comb begin
      flags_now.tx_bus_off_flag     = tx_error_count >= CES_BUS_OFF_LIMIT;         // [R1]
      flags_now.tx_bus_passive_flag = tx_error_count >= CES_PASSIVE_LIMIT;         // [R2]
      flags_now.rx_bus_passive_flag = {1'b0, rx_error_count} >= CES_PASSIVE_LIMIT; // [R3]
      flags_now.tx_warning_flag     = in_warning(tx_error_count);                  // [R4]
      flags_now.rx_warning_flag     = in_warning({1'b0, rx_error_count});          // [R5]
      flags_now.any_warning_flag    = flags_now.tx_warning_flag
                                      | flags_now.rx_warning_flag;                 // [R6]
   end

   // Registered copy drives the output port
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_flags_reg <= '0;
      end else begin
         err_flags_reg <= flags_now;
      end
   end

   // ----------------------------------------------------------------------
   // FIFO pending and overflow
   // ----------------------------------------------------------------------
   // Only enabled sources count as pending
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fifo_event_pending_reg <= '0;
      end else begin
         fifo_event_pending_reg <= fifo_irq_src & fifo_enable_reg;        // [R9]
      end
   end

   // Sticky; a new overflow in the clearing cycle wins over the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fifo_overflowed_reg <= '0;
      end else begin
         fifo_overflowed_reg <= (fifo_overflowed_reg & ~fifo_ovf_clear)
                                | fifo_ovf_event;                        // [R10]
      end
   end

   // Interrupt code follows the lowest pending FIFO, else unmasked overrun, else none
   always_comb begin
      if (|fifo_event_pending_reg) begin
         interrupt_code_next = lowest_index(fifo_event_pending_reg);     // [R11]
      end else if (irq_status_reg[CES_IRQ_OVERRUN] && irq_mask_reg[CES_IRQ_OVERRUN]) begin
         interrupt_code_next = CES_CODE_OVERRUN;
      end else begin
         interrupt_code_next = CES_CODE_NONE;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         interrupt_code_reg <= CES_CODE_NONE;
      end else begin
         interrupt_code_reg <= interrupt_code_next;
      end
   end

   // ----------------------------------------------------------------------
   // Interrupt status and mask
   // ----------------------------------------------------------------------
   // Events: any overflow, any error-state change, entry into bus-off
   always_comb begin
      irq_events                    = '0;
      irq_events[CES_IRQ_OVERRUN]   = |fifo_ovf_event;                   // [R12]
      irq_events[CES_IRQ_STATE_CHG] = flags_now != err_flags_reg;
      irq_events[CES_IRQ_BUS_OFF]   = flags_now.tx_bus_off_flag
                                      & ~err_flags_reg.tx_bus_off_flag;
      irq_clear                     = '0;
      if (wr_commit && paddr == CES_OFF_IRQ_STATUS && pstrb[0]) begin
         irq_clear = pwdata[CES_IRQ_BITS-1:0];
      end
   end

   // Write one to clear; an event in the same cycle keeps the bit set
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status_reg <= '0;
      end else begin
         irq_status_reg <= (irq_status_reg & ~irq_clear) | irq_events;   // [R12]
      end
   end

   // Level output, high while any unmasked status bit is set
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |(irq_status_reg & irq_mask_reg);
      end
   end

   // ----------------------------------------------------------------------
   // Software-written controls
   // ----------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask_reg <= '0;
      end else if (wr_commit && paddr == CES_OFF_IRQ_MASK && pstrb[0]) begin
         irq_mask_reg <= pwdata[CES_IRQ_BITS-1:0];
      end
   end

   // Byte lanes honoured so one FIFO group can be enabled alone
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fifo_enable_reg <= '0;
      end else if (wr_commit && paddr == CES_OFF_FIFO_EN) begin
         for (int b = 0; b < 4; b++) begin
            if (pstrb[b]) begin
               fifo_enable_reg[b*8 +: 8] <= pwdata[b*8 +: 8];
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------------
   assign setup     = psel && !penable;
   assign wr_commit = psel && penable && pwrite && pready_reg
                      && apb_state_reg == CES_ST_ACCESS;

   // Address decode; count, pending and overflow registers ignore writes without error
   always_comb begin
      addr_hit  = 1'b1;
      read_word = CES_RESET_WORD;
      if (paddr == CES_OFF_ERR_COUNT) begin
         read_word[31:22]               = 10'h000;                       // [R8]
         read_word[CES_BIT_TX_BUS_OFF]  = flags_now.tx_bus_off_flag;     // [R1]
         read_word[CES_BIT_TX_PASSIVE]  = flags_now.tx_bus_passive_flag; // [R2]
         read_word[CES_BIT_RX_PASSIVE]  = flags_now.rx_bus_passive_flag; // [R3]
         read_word[CES_BIT_TX_WARNING]  = flags_now.tx_warning_flag;     // [R4]
         read_word[CES_BIT_RX_WARNING]  = flags_now.rx_warning_flag;     // [R5]
         read_word[CES_BIT_ANY_WARNING] = flags_now.any_warning_flag;    // [R6]
         read_word[15:8]                = tx_error_count[7:0];           // [R7]
         read_word[7:0]                 = rx_error_count;                // [R7]
      end else if (paddr == CES_OFF_FIFO_PEND) begin
         read_word = fifo_event_pending_reg;                             // [R9]
      end else if (paddr == CES_OFF_FIFO_OVF) begin
         read_word = fifo_overflowed_reg;                                // [R10]
      end else if (paddr == CES_OFF_IRQ_STATUS) begin
         read_word[CES_IRQ_BITS-1:0] = irq_status_reg;
      end else if (paddr == CES_OFF_IRQ_MASK) begin
         read_word[CES_IRQ_BITS-1:0] = irq_mask_reg;
      end else if (paddr == CES_OFF_FIFO_EN) begin
         read_word = fifo_enable_reg;
      end else begin
         addr_hit = 1'b0;
      end
   end

   // Two-state sequencer: answer always lands in the first access cycle
   always_comb begin
      apb_state_next = CES_ST_IDLE;
      case (apb_state_reg)
         CES_ST_IDLE:   apb_state_next = setup ? CES_ST_ACCESS : CES_ST_IDLE;
         CES_ST_ACCESS: apb_state_next = setup ? CES_ST_ACCESS : CES_ST_IDLE;
         default:       apb_state_next = CES_ST_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         apb_state_reg <= CES_ST_IDLE;
      end else begin
         apb_state_reg <= apb_state_next;
      end
   end

   // Ready, data and error are captured at the setup edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= CES_RESET_WORD;
      end else begin
         pready_reg  <= setup;
         pslverr_reg <= setup && !addr_hit;
         if (setup && !pwrite && addr_hit) begin
            prdata_reg <= read_word;
         end else if (setup) begin
            prdata_reg <= CES_RESET_WORD;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign prdata                 = prdata_reg;
   assign pready                 = pready_reg;
   assign pslverr                = pslverr_reg;
   assign err_flags              = err_flags_reg;
   assign interrupt_code         = interrupt_code_reg;
   assign rx_buffer_overrun_flag = irq_status_reg[CES_IRQ_OVERRUN];
   assign irq                    = irq_reg;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   sequence s_tx_error_step;
      err_events.tx_error && !err_events.bus_recovered
         && tx_error_count < CES_BUS_OFF_LIMIT - CES_STEP_ERROR;
   endsequence

   a_bus_off_flag: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 err_flags.tx_bus_off_flag == ($past(tx_error_count) >= 9'h100))
      else $error("bus-off flag disagrees with count"); // [R1]

   a_tx_passive_flag: assert property (@(posedge pclk) disable iff (!presetn)
      (tx_error_count >= 9'h080) |=> err_flags.tx_bus_passive_flag)
      else $error("tx passive flag missing"); // [R2]

   a_rx_passive_flag: assert property (@(posedge pclk) disable iff (!presetn)
      (rx_error_count < 8'h80) |=> !err_flags.rx_bus_passive_flag)
      else $error("rx passive flag wrongly set"); // [R3]

   a_tx_warn_band: assert property (@(posedge pclk) disable iff (!presetn)
      (tx_error_count == 9'h05f || tx_error_count == 9'h080)
         |=> !err_flags.tx_warning_flag)
      else $error("tx warning outside band"); // [R4]

   a_rx_warn_band: assert property (@(posedge pclk) disable iff (!presetn)
      (rx_error_count >= 8'h60 && rx_error_count <= 8'h7f)
         |=> err_flags.rx_warning_flag && err_flags.any_warning_flag)
      else $error("rx warning not shown"); // [R5]

   a_any_warning: assert property (@(posedge pclk) disable iff (!presetn)
      err_flags.any_warning_flag == (err_flags.tx_warning_flag | err_flags.rx_warning_flag))
      else $error("combined warning wrong"); // [R6]

   a_count_read: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && paddr == 8'h00) |=> pready
         && prdata[15:8] == $past(tx_error_count[7:0]) && prdata[31:22] == 10'h000)
      else $error("error-count read wrong"); // [R7] [R8]

   a_tx_count_step: assert property (@(posedge pclk) disable iff (!presetn)
      s_tx_error_step |=> tx_error_count == $past(tx_error_count) + 9'h008)
      else $error("tx count did not add eight"); // [R13]

   a_pending_enabled: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 fifo_event_pending_reg == ($past(fifo_irq_src) & $past(fifo_enable_reg)))
      else $error("pending bits wrong"); // [R9]

   a_overflow_sticky: assert property (@(posedge pclk) disable iff (!presetn)
      fifo_ovf_event[0] |=> fifo_overflowed_reg[0] [*2] or ##1 $past(fifo_ovf_clear[0]))
      else $error("overflow bit lost"); // [R10]

   a_code_fifo0: assert property (@(posedge pclk) disable iff (!presetn)
      fifo_event_pending_reg[0] |=> interrupt_code == 7'h00)
      else $error("interrupt code not fifo 0"); // [R11]

   a_overrun_flag: assert property (@(posedge pclk) disable iff (!presetn)
      (|fifo_ovf_event) |=> rx_buffer_overrun_flag)
      else $error("overrun flag not raised"); // [R12]

endmodule // ces_status

// ==== ces_ctrl_model.sv ====
// Controller-side model: turns a bench request into a one-cycle error event.
// Assumes fire is raised for one cycle just after a rising edge.
`timescale 1ns/1ps
module ces_ctrl_model (
   input  wire logic                pclk,
   input  wire logic                fire,
   input  wire logic [2:0]          kind,
   output ces_pkg::ces_err_events_s err_events
);
   import ces_pkg::*;
   // One-hot pulse, transmit error is the top bit; one event per frame
   always_ff @(posedge pclk) begin
      err_events <= fire ? ces_err_events_s'(6'h20 >> kind) : '0;
   end
endmodule // ces_ctrl_model

// ==== tb_top.sv ====
// Self-checking bench for the CAN error and FIFO status block.
// Assumes the APB slave answers within a few cycles of setup.
`timescale 1ns/1ps
module tb_top;
   import ces_pkg::*;
   logic            pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fire = 0;
   logic [7:0]      paddr = '0;
   logic [2:0]      kind = '0;
   logic [31:0]     pwdata = '0, prdata, rd, src, en, e;
   logic [31:0]     fifo_irq_src = '0, fifo_ovf_event = '0, fifo_ovf_clear = '0;
   logic            pready, pslverr, err, irq, rx_buffer_overrun_flag;
   logic [6:0]      interrupt_code;
   ces_err_events_s err_events;
   ces_err_flags_s  err_flags;
   int              fails = 0, compares = 0, seed = 32'h5877, tx = 0, rx = 0, k;

   always #2.5 pclk = ~pclk;
   ces_ctrl_model i_model (.pclk(pclk), .fire(fire), .kind(kind), .err_events(err_events));
   ces_status i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pstrb(4'hf), .prdata, .pready, .pslverr, .err_events, .fifo_irq_src,
      .fifo_ovf_event, .fifo_ovf_clear, .err_flags, .interrupt_code,
      .rx_buffer_overrun_flag, .irq);

   // ------------------------------------------------------------
   // Tasks and expectations
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      compares++;
      if (g !== x) begin
         fails++;
         $display("CHECK FAILED at %0t got %h exp %h", $time, g, x);
      end
   endtask
   // Holds the request until pready; released one edge before the next call
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask
   task automatic pulse(input int q);
      kind <= 3'(q);
      fire <= 1;
      @(posedge pclk);
      fire <= 0;
      repeat (4) @(posedge pclk);
   endtask
   function automatic logic [31:0] exp_err(int t, int r);
      logic tw, rw;
      tw = t >= 96 && t < 128;
      rw = r >= 96 && r < 128;
      return {10'h0, t >= 256, t >= 128, r >= 128, tw, rw, tw | rw, t[7:0], r[7:0]};
   endfunction
   task automatic tally_and_finish;
      if (fails == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      for (int i = 0; i < 3; i++) begin
         apb(0, 8'(i * 4), 0);
         chk(rd, 0);
      end
      apb(1, 8'h00, 32'hffffffff);
      apb(0, 8'h00, 0);
      chk(rd, 0);
      apb(0, 8'h20, 0);
      chk({rd[30:0], err}, 1);
      // Random error traffic, biased early so the transmitter reaches bus-off
      for (int i = 0; i < 110; i++) begin
         k = $unsigned($random(seed)) % 5;
         if (k == 1 && i < 80) k = 0;
         pulse(k);
         case (k)
            0: tx = tx >= 248 ? 256 : tx + 8;
            1: tx = (tx == 256 || tx == 0) ? tx : tx - 1;
            2: rx = rx == 255 ? rx : rx + 1;
            3: rx = rx > 247 ? 255 : rx + 8;
            default: rx = rx > 127 ? 120 : (rx == 0 ? 0 : rx - 1);
         endcase
         e = exp_err(tx, rx);
         apb(0, 8'h00, 0);
         chk(rd, e);
         chk(err_flags, e[21:16]);
      end
      pulse(5);
      apb(0, 8'h00, 0);
      chk(rd, 0);
      // Every FIFO code, with random higher sources pending too
      apb(1, 8'h14, 32'hffffffff);
      for (int i = 0; i < 32; i++) begin
         fifo_irq_src <= ($random(seed) & (32'hffffffff << i)) | (32'h1 << i);
         repeat (3) @(posedge pclk);
         chk(interrupt_code, i);
      end
      src = $random(seed);
      en = $random(seed);
      fifo_irq_src <= src;
      apb(1, 8'h14, en);
      apb(0, 8'h04, 0);
      chk(rd, src & en);
      fifo_irq_src <= 0;
      // Overflow, interrupt mask and write-one-to-clear
      src = $random(seed) | 1;
      fifo_ovf_event <= src;
      @(posedge pclk);
      fifo_ovf_event <= 0;
      repeat (2) @(posedge pclk);
      apb(0, 8'h08, 0);
      chk(rd, src);
      chk(rx_buffer_overrun_flag, 1);
      chk(irq, 0);
      apb(1, 8'h10, 1);
      @(posedge pclk);
      chk(irq, 1);
      chk(interrupt_code, CES_CODE_OVERRUN);
      apb(1, 8'h0c, 1);
      @(posedge pclk);
      chk({irq, rx_buffer_overrun_flag}, 0);
      chk(interrupt_code, CES_CODE_NONE);
      fifo_ovf_clear <= src;
      @(posedge pclk);
      fifo_ovf_clear <= 0;
      apb(0, 8'h08, 0);
      chk(rd, 0);
      tally_and_finish();
   end

   // Watchdog, far beyond the roughly one thousand cycles the tests need
   initial begin
      #60000;
      fails++;
      tally_and_finish();
   end
endmodule // tb_top
